// *** hdl/pcs_pkg.sv ***
// Constants shared by the processor control-signal logic.
// Assumes a 20 MHz core clock; all times are converted to cycles here.
package pcs_pkg;

   // Core clock
   localparam int unsigned CLK_MHZ      = 20;
   localparam int unsigned CLK_PERIOD_NS = 50;

   // Reset release delay after last regulator (least time, 2.0 ms)
   localparam int unsigned RST_DLY_US   = 2000;
   localparam int unsigned RST_DLY_CYC  = RST_DLY_US * CLK_MHZ;
   // Fault persistence before reset assert (1.8 ms)
   localparam int unsigned FLT_RST_US   = 1800;
   localparam int unsigned FLT_RST_CYC  = FLT_RST_US * CLK_MHZ;
   // Fault persistence before power-off (100 ms)
   localparam int unsigned FLT_OFF_US   = 100000;
   localparam int unsigned FLT_OFF_CYC  = FLT_OFF_US * CLK_MHZ;
   // Shutdown warning: one 32 kHz period, rounded up
   localparam int unsigned WARN_NS      = 31250;
   localparam int unsigned WARN_CYC     =
      (WARN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Timer counter width, large enough for the 100 ms count
   localparam int unsigned TMR_W        = 21;

   // Register page and offsets
   localparam logic       PAGE_MAIN      = 1'h0;
   localparam logic       PAGE_EXT1      = 1'h1;
   localparam logic [7:0] PG_FAULT_OFS   = 8'hE8;
   localparam logic [7:0] CTRL_OFS       = 8'h20;
   localparam logic [7:0] FLT_INT_OFS    = 8'h21;
   localparam logic [7:0] FLT_MASK_OFS   = 8'h22;
   localparam logic [7:0] STATUS_OFS     = 8'h23;

   // Field positions
   localparam int unsigned PG_FAULT_BIT  = 0;
   localparam int unsigned CTRL_EDGE_BIT = 0;
   localparam int unsigned CTRL_SINV_BIT = 1;
   localparam int unsigned CTRL_TBB_BIT  = 2;
   localparam int unsigned FLT_BIT       = 0;

   // Reset values
   localparam logic [7:0] PG_FAULT_RST   = 8'h00;
   localparam logic [7:0] CTRL_RST       = 8'h00;
   localparam logic       FLT_MASK_RST   = 1'h0;

   // Power states
   typedef enum logic [1:0] {
      PCS_OFF,
      PCS_STARTUP,
      PCS_ON,
      PCS_WARN
   } pcs_state_e;

endpackage : pcs_pkg

// *** hdl/pcs_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level; no bus coherence.
`timescale 1ns/1ns
module pcs_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         ref_clk_in,
   input  wire logic         resetn_in,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_next;

   // First stage feeds only the second stage
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_out <= sync_next;
      end
   end

endmodule : pcs_sync

// *** hdl/pcs_timer.sv ***
// Persistence timer: counts while enabled, clears when enable drops.
// Assumes LIMIT fits in W bits; saturates at LIMIT.
`timescale 1ns/1ns
module pcs_timer #(
   parameter int unsigned W     = 21,
   parameter logic [W-1:0] LIMIT = '1
) (
   // Clock and reset
   input  wire logic ref_clk_in,
   input  wire logic resetn_in,
   // Control
   input  wire logic en_in,
   output logic      done_out
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   // Restart from zero whenever the condition goes away
   always_comb begin
      if (!en_in) begin
         cnt_next = '0;
      end else if (cnt_reg == LIMIT) begin
         cnt_next = cnt_reg;
      end else begin
         cnt_next = cnt_reg + W'(1);
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign done_out = en_in && (cnt_reg == LIMIT);

endmodule : pcs_timer

// *** hdl/pcs_ctrl.sv ***
// Processor control-signal logic: power-on detect, standby, reset,
// shutdown warning and fault interrupt pins, with their registers.
// Assumes the register engine and sequencer share ref_clk_in; pins are
// asynchronous and synchronised here. Open-drain pins drive low only.
`timescale 1ns/1ns
module pcs_ctrl
   import pcs_pkg::*;
#(
   parameter int unsigned RST_DLY = RST_DLY_CYC,
   parameter int unsigned FLT_RST = FLT_RST_CYC,
   parameter int unsigned FLT_OFF = FLT_OFF_CYC
) (
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       resetn_in,
   // Processor-side input pins
   input  wire logic       power_on_request_in,
   input  wire logic       standby_request_in,
   // Open-drain pins: level, drive value, enable
   input  wire logic       processor_reset_in,
   output logic            processor_reset_drv_out,
   output logic            processor_reset_oe_out,
   input  wire logic       shutdown_warning_in,
   output logic            shutdown_warning_drv_out,
   output logic            shutdown_warning_oe_out,
   input  wire logic       fault_interrupt_in,
   output logic            fault_interrupt_drv_out,
   output logic            fault_interrupt_oe_out,
   // Regulator fault level (analog monitors)
   input  wire logic       fault_in,
   // Sequencer and fuses (same clock)
   input  wire logic       last_reg_enabled_in,
   input  wire logic       turn_off_request_in,
   input  wire logic       otp_fault_mode_in,
   input  wire logic       otp_power_on_edge_in,
   // Register access from the register engine
   input  wire logic       reg_page_in,
   input  wire logic [7:0] reg_addr_in,
   input  wire logic       reg_wr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   // Power state towards sequencer and regulators
   output logic            power_enable_out,
   output logic            standby_out,
   output logic            use_override_cfg_out
);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [5:0] pins_s;
   logic       pwr_req_s, stby_s, fault_s;
   logic [2:0] od_pins_s;

   pcs_sync #(.W(6)) u_sync (
      .ref_clk_in (ref_clk_in),
      .resetn_in  (resetn_in),
      .async_in   ({fault_interrupt_in, shutdown_warning_in,
                    processor_reset_in, fault_in,
                    standby_request_in, power_on_request_in}),
      .sync_out   (pins_s)
   );

   assign pwr_req_s = pins_s[0];
   assign stby_s    = pins_s[1];
   assign fault_s   = pins_s[2];
   assign od_pins_s = pins_s[5:3];

   ////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0] pg_fault_reg, pg_fault_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic       flt_flag_reg, flt_flag_next;
   logic       flt_mask_reg, flt_mask_next;
   logic [7:0] rdata_next;
   logic       pwr_req_d_reg, fault_d_reg;
   logic       wr_main, wr_ext1, flt_rise, flt_clr, try_before_buy_override, fault_mode, edge_sel;
   pcs_state_e state_reg;

   assign wr_main  = reg_wr_in && (reg_page_in == PAGE_MAIN);
   assign wr_ext1  = reg_wr_in && (reg_page_in == PAGE_EXT1);
   assign flt_rise = fault_s && !fault_d_reg;
   assign flt_clr  = wr_main && (reg_addr_in == FLT_INT_OFS)
                     && reg_wdata_in[FLT_BIT];

   // Override registers win over fuses only when enabled
   assign try_before_buy_override        = ctrl_reg[CTRL_TBB_BIT];
   assign fault_mode = try_before_buy_override ? pg_fault_reg[PG_FAULT_BIT]
                           : otp_fault_mode_in;
   assign edge_sel   = try_before_buy_override ? ctrl_reg[CTRL_EDGE_BIT]
                           : otp_power_on_edge_in;

   // Register writes and reads; flag set wins over clear
   always_comb begin
      pg_fault_next = pg_fault_reg;
      ctrl_next     = ctrl_reg;
      flt_mask_next = flt_mask_reg;
      rdata_next    = reg_rdata_out;
      if (wr_ext1 && reg_addr_in == PG_FAULT_OFS) begin
         pg_fault_next = reg_wdata_in;
      end
      if (wr_main && reg_addr_in == CTRL_OFS) begin
         ctrl_next = reg_wdata_in;
      end
      if (wr_main && reg_addr_in == FLT_MASK_OFS) begin
         flt_mask_next = reg_wdata_in[FLT_BIT];
      end
      flt_flag_next = (flt_flag_reg && !flt_clr) || flt_rise;
      if (reg_rd_in) begin
         rdata_next = 8'h00;
         if (reg_page_in == PAGE_EXT1) begin
            rdata_next = (reg_addr_in == PG_FAULT_OFS) ? pg_fault_reg : 8'h00;
         end else begin
            case (reg_addr_in)
               CTRL_OFS:     rdata_next = ctrl_reg;
               FLT_INT_OFS:  rdata_next = {7'h00, flt_flag_reg};
               FLT_MASK_OFS: rdata_next = {7'h00, flt_mask_reg};
               STATUS_OFS:   rdata_next = {od_pins_s, fault_mode,
                                           fault_s, stby_s, state_reg};
               default:      rdata_next = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pg_fault_reg  <= PG_FAULT_RST;
         ctrl_reg      <= CTRL_RST;
         flt_flag_reg  <= 1'h0;
         flt_mask_reg  <= FLT_MASK_RST;
         reg_rdata_out <= 8'h00;
         pwr_req_d_reg <= 1'h0;
         fault_d_reg   <= 1'h0;
      end else begin
         pg_fault_reg  <= pg_fault_next;
         ctrl_reg      <= ctrl_next;
         flt_flag_reg  <= flt_flag_next;
         flt_mask_reg  <= flt_mask_next;
         reg_rdata_out <= rdata_next;
         pwr_req_d_reg <= pwr_req_s;
         fault_d_reg   <= fault_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Timers
   logic seq_done_reg, seq_done_next;
   logic su_fault_reg, su_fault_next;
   logic dly_done, flt_rst_done, flt_off_done, warn_done, flt_tmr_en;

   // Only fault mode watches fault persistence
   assign flt_tmr_en = fault_s && fault_mode && (state_reg != PCS_OFF);

   pcs_timer #(.W(TMR_W), .LIMIT(TMR_W'(RST_DLY - 1))) u_rst_dly (
      .ref_clk_in (ref_clk_in), .resetn_in (resetn_in),
      .en_in      (state_reg == PCS_STARTUP && seq_done_reg),
      .done_out   (dly_done)
   );
   pcs_timer #(.W(TMR_W), .LIMIT(TMR_W'(FLT_RST - 1))) u_flt_rst (
      .ref_clk_in (ref_clk_in), .resetn_in (resetn_in),
      .en_in      (flt_tmr_en),
      .done_out   (flt_rst_done)
   );
   pcs_timer #(.W(TMR_W), .LIMIT(TMR_W'(FLT_OFF - 1))) u_flt_off (
      .ref_clk_in (ref_clk_in), .resetn_in (resetn_in),
      .en_in      (flt_tmr_en),
      .done_out   (flt_off_done)
   );
   pcs_timer #(.W(TMR_W), .LIMIT(TMR_W'(WARN_CYC - 1))) u_warn (
      .ref_clk_in (ref_clk_in), .resetn_in (resetn_in),
      .en_in      (state_reg == PCS_WARN),
      .done_out   (warn_done)
   );

   ////////////////////////////////////////////////////////////////////
   // Power state machine
   pcs_state_e state_next;
   logic       pwr_evt, stby_act;
   logic       rst_oe_next, warn_oe_next, int_oe_next, pwr_en_next, stby_next;

   // Level mode needs only a high level; edge mode a rising edge
   assign pwr_evt  = edge_sel ? (pwr_req_s && !pwr_req_d_reg)
                              : pwr_req_s;
   assign stby_act = stby_s ^ ctrl_reg[CTRL_SINV_BIT];

   always_comb begin
      state_next    = state_reg;
      seq_done_next = seq_done_reg;
      su_fault_next = su_fault_reg;
      case (state_reg)
         PCS_OFF: begin
            seq_done_next = 1'h0;
            su_fault_next = 1'h0;
            if (pwr_evt) begin
               state_next = PCS_STARTUP;
            end
         end
         PCS_STARTUP: begin
            seq_done_next = seq_done_reg || last_reg_enabled_in;
            su_fault_next = su_fault_reg || fault_s;
            if (turn_off_request_in || flt_off_done) begin
               state_next = PCS_WARN;
            end else if (dly_done) begin
               state_next = PCS_ON;
            end
         end
         PCS_ON: begin
            if (turn_off_request_in || flt_off_done) begin
               state_next = PCS_WARN;
            end
         end
         PCS_WARN: begin
            if (warn_done) begin
               state_next = PCS_OFF;
            end
         end
         default: state_next = PCS_OFF;
      endcase
   end

   // Pin and power outputs, registered
   always_comb begin
      // Default mode: reset follows only power state
      rst_oe_next  = (state_next != PCS_ON)
                     || (fault_mode && (su_fault_next || flt_rst_done));
      warn_oe_next = (state_next == PCS_WARN);
      int_oe_next  = flt_flag_next && !flt_mask_next;
      pwr_en_next  = (state_next == PCS_STARTUP)
                     || (state_next == PCS_ON);
      stby_next    = (state_next == PCS_ON) && stby_act;
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg               <= PCS_OFF;
         seq_done_reg            <= 1'h0;
         su_fault_reg            <= 1'h0;
         processor_reset_oe_out  <= 1'h1;
         shutdown_warning_oe_out <= 1'h0;
         fault_interrupt_oe_out  <= 1'h0;
         power_enable_out        <= 1'h0;
         standby_out             <= 1'h0;
      end else begin
         state_reg               <= state_next;
         seq_done_reg            <= seq_done_next;
         su_fault_reg            <= su_fault_next;
         processor_reset_oe_out  <= rst_oe_next;
         shutdown_warning_oe_out <= warn_oe_next;
         fault_interrupt_oe_out  <= int_oe_next;
         power_enable_out        <= pwr_en_next;
         standby_out             <= stby_next;
      end
   end

   // Open-drain pins only ever pull low
   assign processor_reset_drv_out  = 1'h0;
   assign shutdown_warning_drv_out = 1'h0;
   assign fault_interrupt_drv_out  = 1'h0;
   assign use_override_cfg_out     = try_before_buy_override;

   ////////////////////////////////////////////////////////////////////
   // Checks
   logic [9:0] warn_len_reg;
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         warn_len_reg <= 10'h000;
      end else begin
         warn_len_reg <= shutdown_warning_oe_out ? warn_len_reg + 10'h001
                                                 : 10'h000;
      end
   end

   AST_WARN_LEN: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      $fell(shutdown_warning_oe_out) |-> warn_len_reg == 10'(WARN_CYC))
      else $error("shutdown warning length wrong");
   AST_IRQ_SET: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      flt_rise && !flt_mask_next |=> fault_interrupt_oe_out)
      else $error("interrupt not raised on fault");
   AST_SET_WINS: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      flt_rise && flt_clr |=> flt_flag_reg)
      else $error("fault event lost on clear");
   AST_W1C: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      flt_clr && !flt_rise |=> !fault_interrupt_oe_out)
      else $error("interrupt not released after clear");
   AST_DEF_RST: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      !fault_mode && state_reg == PCS_ON && $past(state_reg) == PCS_ON
      |-> !processor_reset_oe_out)
      else $error("reset asserted in default mode while on");
   AST_FLT_RST: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      flt_rst_done && fault_mode |=> processor_reset_oe_out)
      else $error("reset not asserted on persistent fault");
   AST_FLT_OFF: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      flt_off_done && state_reg == PCS_ON |=> state_reg == PCS_WARN
      ##1 shutdown_warning_oe_out)
      else $error("no power-off on long fault");
   AST_STBY: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      state_reg == PCS_ON && state_next == PCS_ON && stby_act
      |=> standby_out)
      else $error("standby not entered");
   AST_POWER_ON_REQUEST: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      state_reg == PCS_OFF && !edge_sel && pwr_req_s
      |=> state_reg == PCS_STARTUP && power_enable_out)
      else $error("level power-on request ignored");
   AST_RST_DLY: assert property (@(posedge ref_clk_in)
      disable iff (!resetn_in)
      $rose(state_reg == PCS_ON) |-> $past(seq_done_reg))
      else $error("reset released before sequence end");

endmodule : pcs_ctrl

// *** verif/pcs_proc_model.sv ***
// Processor-side partner: owns the request pins and the pull-ups.
// Assumes the bench commands the request levels; pins idle high.
`timescale 1ns/1ns
module pcs_proc_model (
   // Commands from the bench
   input  wire logic power_on_request_cmd_in,
   input  wire logic stby_cmd_in,
   // Open-drain enables from the device
   input  wire logic rst_oe_in,
   input  wire logic warn_oe_in,
   input  wire logic int_oe_in,
   // Resolved pin levels
   output logic      power_on_request_out,
   output logic      standby_request_out,
   output logic      rst_pin_out,
   output logic      warn_pin_out,
   output logic      int_pin_out
);
   // Processor drives the request pins
   assign power_on_request_out = power_on_request_cmd_in;
   assign standby_request_out  = stby_cmd_in;
   // Pull-ups win unless the device sinks the line
   assign rst_pin_out  = rst_oe_in ? 1'b0 : 1'b1;
   assign warn_pin_out = warn_oe_in ? 1'b0 : 1'b1;
   assign int_pin_out  = int_oe_in ? 1'b0 : 1'b1;
endmodule : pcs_proc_model

// *** verif/tb_pmic_control_signal_logic.sv ***
// Self-checking bench for the control-signal logic.
// Assumes short timer parameters; register model kept in an array.
`timescale 1ns/1ns
module tb_pmic_control_signal_logic;
   import pcs_pkg::*;
   localparam int RD = 20;
   localparam int FR = 30;
   localparam int FO = 60;
   logic ref_clk_in = 0, resetn_in = 0, power_on_request = 0, stby = 0, fault = 0;
   logic last_reg = 0, toff = 0, pg = 0, wr = 0, rd = 0;
   logic otp_fm = 0, ovr;
   logic [2:0] drv;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic rst_oe, warn_oe, int_oe, pwr_en, stby_out, por, sbr, rp, wp, ip;
   int err_count = 0, checks = 0, n, k;
   int mreg[int];
   logic [7:0] d;
   ////////////////////////////////////////////////////////////////////
   // Clock, partner and design
   always #25 ref_clk_in = ~ref_clk_in;
   pcs_proc_model pcs_proc_model_inst (.power_on_request_cmd_in(power_on_request),
      .stby_cmd_in(stby), .rst_oe_in(rst_oe), .warn_oe_in(warn_oe),
      .int_oe_in(int_oe), .power_on_request_out(por),
      .standby_request_out(sbr), .rst_pin_out(rp), .warn_pin_out(wp),
      .int_pin_out(ip));
   pcs_ctrl #(.RST_DLY(RD), .FLT_RST(FR), .FLT_OFF(FO)) pcs_ctrl_inst (
      .ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .power_on_request_in(por), .standby_request_in(sbr),
      .processor_reset_in(rp), .processor_reset_drv_out(drv[2]),
      .processor_reset_oe_out(rst_oe), .shutdown_warning_in(wp),
      .shutdown_warning_drv_out(drv[1]), .shutdown_warning_oe_out(warn_oe),
      .fault_interrupt_in(ip), .fault_interrupt_drv_out(drv[0]),
      .fault_interrupt_oe_out(int_oe), .fault_in(fault),
      .last_reg_enabled_in(last_reg), .turn_off_request_in(toff),
      .otp_fault_mode_in(otp_fm), .otp_power_on_edge_in(1'b0),
      .reg_page_in(pg), .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .power_enable_out(pwr_en), .standby_out(stby_out),
      .use_override_cfg_out(ovr));
   ////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Writes land in the model only for storage registers
   task automatic wreg(input logic p, input logic [7:0] a, input logic [7:0] v);
      @(negedge ref_clk_in);
      pg = p; addr = a; wdata = v; wr = 1;
      @(negedge ref_clk_in);
      wr = 0;
      if (a != FLT_INT_OFS) mreg[{p, a}] = v;
   endtask : wreg
   task automatic rreg(input logic p, input logic [7:0] a);
      @(negedge ref_clk_in);
      pg = p; addr = a; rd = 1;
      @(negedge ref_clk_in);
      rd = 0;
      @(negedge ref_clk_in);
      d = rdata;
   endtask : rreg
   function automatic logic [7:0] mexp(input logic p, input logic [7:0] a);
      return mreg.exists({p, a}) ? 8'(mreg[{p, a}]) : 8'h00;
   endfunction : mexp
   function automatic logic sg(input int s);
      case (s)
         0: return rst_oe;
         1: return warn_oe;
         2: return int_oe;
         default: return pwr_en;
      endcase
   endfunction : sg
   // Bounded wait; the count tells how long the design took
   task automatic wt(input int s, input logic v, input int lim, output int c);
      c = 0;
      while (sg(s) !== v && c < lim) begin
         @(negedge ref_clk_in);
         c++;
      end
   endtask : wt
   task automatic go_on(input bit keep);
      power_on_request = 1;
      wt(3, 1, 10, n);
      chk(pwr_en, 1);
      power_on_request = 0;
      @(negedge ref_clk_in) last_reg = 1;
      @(negedge ref_clk_in) last_reg = 0;
      if (!keep) begin
         wt(0, 0, 3 * RD, n);
         chk(16'(n >= RD && n <= 2 * RD), 1);
      end
   endtask : go_on
   task automatic turn_off;
      wt(1, 1, 2 * FO, n);
      chk(rst_oe, 1);
      n = 0;
      while (warn_oe === 1 && n < 2000) begin
         @(negedge ref_clk_in);
         n++;
      end
      chk(16'(n), 16'(WARN_CYC));
      chk(pwr_en, 0);
   endtask : turn_off
   task final_report;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////
   // Watchdog sized well above the expected run
   initial begin
      #(20000 * 50);
      err_count++;
      final_report;
   end
   // Main sequence
   initial begin
      void'($urandom(32'hD239));
      repeat (5) @(negedge ref_clk_in);
      resetn_in = 1;
      repeat (3) @(negedge ref_clk_in);
      chk({rst_oe, warn_oe, int_oe, pwr_en}, 16'h8);
      rreg(0, STATUS_OFS);
      chk(d, 8'hC0);
      for (k = 0; k < 5; k++) begin
         rreg(k == 4, k == 4 ? PG_FAULT_OFS : 8'h20 + 8'(k));
         chk(d, k == 3 ? 8'hC0 : 8'h00);
      end
      rreg(0, 8'h7F);
      chk(d, 8'h00);
      // Fuse path selects fault mode while the override is off
      otp_fm = 1;
      rreg(0, STATUS_OFS);
      chk(d, 8'hD0);
      otp_fm = 0;
      // Level detect start-up, default mode
      go_on(0);
      stby = 1;
      repeat (4) @(negedge ref_clk_in);
      chk(stby_out, 1);
      wreg(0, CTRL_OFS, 8'h02);
      repeat (4) @(negedge ref_clk_in);
      chk(stby_out, 0);
      stby = 0;
      repeat (4) @(negedge ref_clk_in);
      chk(stby_out, 1);
      wreg(0, CTRL_OFS, 8'h00);
      stby = 0;
      // Long fault, default mode: only the interrupt reacts
      fault = 1;
      repeat (FO + 10) @(negedge ref_clk_in);
      chk({rst_oe, int_oe, pwr_en}, 16'h3);
      rreg(0, FLT_INT_OFS);
      chk(d, 8'h01);
      wreg(0, FLT_MASK_OFS, 8'h01);
      repeat (2) @(negedge ref_clk_in);
      chk(int_oe, 0);
      wreg(0, FLT_MASK_OFS, 8'h00);
      fault = 0;
      repeat (4) @(negedge ref_clk_in);
      chk(int_oe, 1);
      wreg(0, FLT_INT_OFS, 8'h01);
      repeat (2) @(negedge ref_clk_in);
      chk(int_oe, 0);
      // Clear lands on the same edge as a new fault: the set must win
      fault = 1;
      @(negedge ref_clk_in);
      wreg(0, FLT_INT_OFS, 8'h01);
      rreg(0, FLT_INT_OFS);
      chk(d, 8'h01);
      fault = 0;
      @(negedge ref_clk_in) toff = 1;
      @(negedge ref_clk_in) toff = 0;
      turn_off;
      // Override config: fault mode, edge detect
      wreg(0, CTRL_OFS, 8'h05);
      wreg(1, PG_FAULT_OFS, 8'h01);
      rreg(0, CTRL_OFS);
      chk(d, mexp(0, CTRL_OFS));
      rreg(1, PG_FAULT_OFS);
      chk(d, mexp(1, PG_FAULT_OFS));
      chk({drv, ovr}, 16'h1);
      fault = 1;
      for (k = 0; k < 2; k++) begin
         go_on(1);
         repeat (RD + 6) @(negedge ref_clk_in);
         chk(rst_oe, 1);
         turn_off;
      end
      fault = 0;
      wreg(0, FLT_INT_OFS, 8'h01);
      go_on(0);
      // Short glitches never reach the reset threshold
      for (k = 0; k < 6; k++) begin
         fault = 1;
         repeat ($urandom_range(FR - 6, 1)) @(negedge ref_clk_in);
         fault = 0;
         repeat (4) @(negedge ref_clk_in);
         chk(rst_oe, 0);
      end
      fault = 1;
      wt(0, 1, 2 * FR, n);
      chk(16'(n >= FR && n <= FR + 4), 1);
      fault = 0;
      repeat (8) @(negedge ref_clk_in);
      chk({rst_oe, pwr_en}, 16'h1);
      final_report;
   end
endmodule : tb_pmic_control_signal_logic
